//--- rtl/ems_pkg.sv
// Constants and carriers for the error record miscellaneous syndrome bank.
// Assumes one node owning all records, a 64-bit frame port and a select register view.
package ems_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // Frame layout: one 64-byte slot per record
    localparam logic [11:0] MISC_ONE_OFF = 12'h028;
    localparam logic [11:0] MISC_TWO_OFF = 12'h030;
    localparam logic [11:0] MISC_THREE_OFF = 12'h038;
    localparam int REC_STRIDE = 64;
    localparam int REC_SHIFT = $clog2(REC_STRIDE);
    localparam int MAX_RECORDS = 32;

    ////////////////////////////////////////////////////////////////////////////////
    // Field positions inside the syndrome registers
    localparam int UNIT_LSB = 0;
    localparam int UNIT_W = 32;
    localparam int DETAIL_LSB = 0;
    localparam int DETAIL_W = 32;
    localparam int COUNT_LSB = 32;
    localparam int COUNT_W = 16;
    localparam int OVERFLOW_BIT = 63;
    localparam int LANE_W = 32;

    ////////////////////////////////////////////////////////////////////////////////
    // Reset values and encodings
    localparam logic [15:0] COUNT_RESET = 16'h0000;
    localparam logic OVERFLOW_RESET = 1'b0;
    localparam logic [5:0] SELECT_RESET = 6'h00;
    localparam logic [1:0] TS_NONE = 2'h0;
    localparam logic [1:0] WHICH_NONE = 2'h0;
    localparam logic [1:0] WHICH_ONE = 2'h1;
    localparam logic [1:0] WHICH_TWO = 2'h2;
    localparam logic [1:0] WHICH_THREE = 2'h3;

    // Width of a system register access
    typedef enum logic [1:0] {HALF_FULL, HALF_LOW, HALF_HIGH} ems_half_e;

    // One register access, from either port
    typedef struct packed {
        logic valid;
        logic write;
        logic fromFrame;
        logic [5:0] rec;
        logic [1:0] which;
        ems_half_e half;
        logic [63:0] wdata;
    } ems_req_s;

    // One newly recorded error from the record logic
    typedef struct packed {
        logic valid;
        logic [5:0] rec;
        logic [31:0] unit;
        logic [31:0] detail;
        logic corrected;
    } ems_err_s;

endpackage

//--- rtl/ems_mem.sv
// Small word store with per-lane write enables and a registered read port.
// Assumes lanes of 32 bits; contents have no reset and survive any reset.
`timescale 1ns/10ps
`default_nettype none

module ems_mem
    import ems_pkg::*;
#(
    parameter int WIDTH = 64,
    parameter int DEPTH = 4,
    parameter int AW = 2
) (
    input wire logic clk,
    input wire logic [WIDTH/LANE_W-1:0] wrLanes,
    input wire logic [AW-1:0] wrAddr,
    input wire logic [WIDTH-1:0] wrData,
    input wire logic [AW-1:0] rdAddr,
    output logic [WIDTH-1:0] rdData
);

    if (WIDTH % LANE_W != 0 || DEPTH < 1 || (1 << AW) < DEPTH) begin : badShape
        $error("ems_mem: width must be whole lanes and address must cover depth");
    end

    logic [WIDTH-1:0] store [DEPTH];

    ////////////////////////////////////////////////////////////////////////////////
    // Lane writes from one process, so the store has a single writer
    always_ff @(posedge clk) begin
        for (int l = 0; l < WIDTH / LANE_W; l++) begin
            if (wrLanes[l]) begin
                store[wrAddr][l*LANE_W +: LANE_W] <= wrData[l*LANE_W +: LANE_W];
            end
        end
    end

    always_ff @(posedge clk) begin
        rdData <= store[rdAddr];
    end

endmodule

`default_nettype wire

//--- rtl/ems_misc_syndrome.sv
// Miscellaneous syndrome registers one to three for every error record of a node.
// Assumes status, feature and control logic outside; all inputs on clk.
//
// How it works
// - writing zero returns syndrome fields to initial
// - zero write to overflow withdraws interrupt
// - read-only timestamp counts as write-zero compliant
// - register one at 0x028 plus 64n
// - register two at 0x030 plus 64n
// - register three at 0x038 plus 64n
// - registers two, three absent without v1.1
// - timestamp support makes register three timestamp
// - timestamp meaningful only while record valid
// - timestamp read-only or writable, chosen once
// - timestamp unknown at cold reset, kept otherwise
// - corrected error counter stays writable
// - latest-error fields ignore writes while MV
// - interrupts disabled until control field enables
// - first record's feature field describes node
// - select field picks record for full window
// - 32-bit view uses low and high windows
`timescale 1ns/10ps
`default_nettype none

module ems_misc_syndrome
    import ems_pkg::*;
#(
    parameter int NUM_RECORDS = 4,
    parameter bit VERSION_ONE_ONE = 1'b1,
    parameter bit TS_WRITABLE = 1'b0
) (
    input wire logic clk,
    input wire logic reset,
    // Memory-mapped frame, 64-bit
    input wire logic frameValid,
    input wire logic frameWrite,
    input wire logic [11:0] frameAddr,
    input wire logic [63:0] frameWdata,
    output logic frameAck,
    output logic [63:0] frameRdata,
    // System register view through the record select field
    input wire logic selectWrite,
    input wire logic [5:0] selectData,
    output logic [5:0] recordSelect,
    input wire logic sysValid,
    input wire logic sysWrite,
    input wire logic [1:0] sysWhich,
    input wire ems_half_e sysHalf,
    input wire logic [63:0] sysWdata,
    output logic sysAck,
    output logic [63:0] sysRdata,
    // Record logic and node state
    input wire ems_err_s errIn,
    input wire logic [NUM_RECORDS-1:0] statusValid,
    input wire logic [NUM_RECORDS-1:0] recordMiscValid,
    input wire logic [1:0] timestampSupport,
    input wire logic irqEnable,
    input wire logic [63:0] captureTimestamp,
    output logic faultIrq
);

    localparam int AW = (NUM_RECORDS > 1) ? $clog2(NUM_RECORDS) : 1;
    localparam logic [6:0] REC_LIMIT = 7'(NUM_RECORDS);

    if (NUM_RECORDS < 1 || NUM_RECORDS > MAX_RECORDS) begin : badCount
        $error("ems_misc_syndrome: record count out of range");
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Helpers

    // Register number from the offset inside a record slot
    function automatic logic [1:0] decodeOff(input logic [REC_SHIFT-1:0] off);
        if (off == MISC_ONE_OFF[REC_SHIFT-1:0]) begin
            return WHICH_ONE;
        end else if (off == MISC_TWO_OFF[REC_SHIFT-1:0]) begin
            return WHICH_TWO;
        end else if (off == MISC_THREE_OFF[REC_SHIFT-1:0]) begin
            return WHICH_THREE;
        end
        return WHICH_NONE;
    endfunction

    // Lanes touched by an access width
    function automatic logic [1:0] laneMask(input ems_half_e half);
        case (half)
            HALF_LOW: return 2'h1;
            HALF_HIGH: return 2'h2;
            default: return 2'h3;
        endcase
    endfunction

    // Read data as seen through an access width
    function automatic logic [63:0] shapeRead(input logic [63:0] val, input ems_half_e half);
        case (half)
            HALF_LOW: return {32'h0, val[31:0]};
            HALF_HIGH: return {32'h0, val[63:32]};
            default: return val;
        endcase
    endfunction

    // Record index inside the implemented range
    function automatic logic recInRange(input logic [5:0] rec);
        return {1'b0, rec} < REC_LIMIT;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Request selection: frame first, system view otherwise

    ems_req_s frameReq;
    ems_req_s sysReq;
    ems_req_s req;
    logic [31:0] sysLane;

    // Frame slot decode, record number from the 64-byte stride
    assign frameReq.valid = frameValid;
    assign frameReq.write = frameWrite;
    assign frameReq.fromFrame = 1'b1;
    assign frameReq.rec = frameAddr[REC_SHIFT +: 6];
    assign frameReq.which = decodeOff(frameAddr[REC_SHIFT-1:0]);
    assign frameReq.half = HALF_FULL;
    assign frameReq.wdata = frameWdata;

    // Selected-record windows; a half window puts its word on both lanes
    assign sysLane = sysWdata[31:0];
    assign sysReq.valid = sysValid;
    assign sysReq.write = sysWrite;
    assign sysReq.fromFrame = 1'b0;
    assign sysReq.rec = recordSelect;
    assign sysReq.which = sysWhich;
    assign sysReq.half = sysHalf;
    assign sysReq.wdata = (sysHalf == HALF_FULL) ? sysWdata : {sysLane, sysLane};

    assign req = frameValid ? frameReq : sysReq;

    ////////////////////////////////////////////////////////////////////////////////
    // Write qualification

    logic [AW-1:0] reqIdx;
    logic [AW-1:0] capIdx;
    logic reqOk;
    logic capOk;
    logic reqMv;
    logic tsOn;
    logic [1:0] reqLanes;
    logic wrOne;
    logic wrTwo;
    logic wrThree;
    logic unitWr;
    logic detailWr;
    logic tsWrOk;
    logic tsCap;

    assign reqIdx = req.rec[AW-1:0];
    assign capIdx = errIn.rec[AW-1:0];
    assign reqOk = req.valid && recInRange(req.rec);
    assign capOk = errIn.valid && recInRange(errIn.rec);
    assign reqMv = reqOk && recordMiscValid[reqIdx];
    assign tsOn = timestampSupport != TS_NONE;
    assign reqLanes = laneMask(req.half);

    // Registers two and three exist only with v1.1
    assign wrOne = reqOk && req.write && req.which == WHICH_ONE;
    assign wrTwo = reqOk && req.write && req.which == WHICH_TWO && VERSION_ONE_ONE;
    assign wrThree = reqOk && req.write && req.which == WHICH_THREE && VERSION_ONE_ONE;

    // Latest-error fields hold while the misc-valid bit is set
    assign unitWr = wrOne && reqLanes[0] && !reqMv;
    assign detailWr = wrTwo && reqLanes[0] && !reqMv;

    // Timestamp writes follow the build-time choice
    assign tsWrOk = tsOn ? (TS_WRITABLE && !reqMv) : 1'b1;
    assign tsCap = capOk && tsOn;

    ////////////////////////////////////////////////////////////////////////////////
    // Storage: unit and detail in one store, timestamps in the other

    logic [1:0] infoLanes;
    logic [1:0] tsLanes;
    logic [AW-1:0] infoAddr;
    logic [AW-1:0] tsAddr;
    logic [63:0] infoData;
    logic [63:0] tsData;
    logic [63:0] infoRd;
    logic [63:0] tsRd;

    // Capture beats a software write in the same cycle
    assign infoLanes = capOk ? 2'h3 : {detailWr, unitWr};
    assign infoAddr = capOk ? capIdx : reqIdx;
    assign infoData = capOk ? {errIn.detail, errIn.unit} : {req.wdata[31:0], req.wdata[31:0]};
    assign tsLanes = tsCap ? 2'h3 : ((wrThree && tsWrOk) ? reqLanes : 2'h0);
    assign tsAddr = tsCap ? capIdx : reqIdx;
    assign tsData = tsCap ? captureTimestamp : req.wdata;

    // No reset on either store: cold reset leaves them unknown
    ems_mem #(.WIDTH(64), .DEPTH(NUM_RECORDS), .AW(AW)) infoStore (
        .clk(clk),
        .wrLanes(infoLanes),
        .wrAddr(infoAddr),
        .wrData(infoData),
        .rdAddr(reqIdx),
        .rdData(infoRd)
    );

    ems_mem #(.WIDTH(64), .DEPTH(NUM_RECORDS), .AW(AW)) stampStore (
        .clk(clk),
        .wrLanes(tsLanes),
        .wrAddr(tsAddr),
        .wrData(tsData),
        .rdAddr(reqIdx),
        .rdData(tsRd)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Corrected error counters and sticky overflow, one pair per record

    logic [COUNT_W-1:0] count [NUM_RECORDS];
    logic overflow [NUM_RECORDS];
    logic [NUM_RECORDS-1:0] overflowVec;

    for (genvar r = 0; r < NUM_RECORDS; r++) begin : rec
        logic bump;
        logic cntWr;
        logic [COUNT_W-1:0] base;
        logic [COUNT_W-1:0] next_count;
        logic wrap;
        logic next_overflow;

        assign bump = capOk && errIn.corrected && capIdx == AW'(r);
        assign cntWr = wrOne && reqLanes[1] && reqIdx == AW'(r);
        assign base = cntWr ? req.wdata[COUNT_LSB +: COUNT_W] : count[r];
        assign next_count = base + COUNT_W'(bump);
        assign wrap = bump && base == {COUNT_W{1'b1}};
        // Wrap sets only when enabled; a zero write clears; set wins
        assign next_overflow = (wrap && irqEnable)
            || (overflow[r] && !(cntWr && !req.wdata[OVERFLOW_BIT]));
        assign overflowVec[r] = overflow[r];

        // Counter and overflow state
        always_ff @(posedge clk) begin
            if (reset) begin
                count[r] <= COUNT_RESET;
                overflow[r] <= OVERFLOW_RESET;
            end else begin
                count[r] <= next_count;
                overflow[r] <= next_overflow;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Answer pipeline: store read in the first cycle, data out in the second

    ems_req_s s1;
    logic s1Ok;
    logic [AW-1:0] s1Idx;
    logic [63:0] oneVal;
    logic [63:0] twoVal;
    logic [63:0] threeVal;
    logic [63:0] regVal;
    logic [63:0] next_rdata;

    // First stage holds the access
    always_ff @(posedge clk) begin
        if (reset) begin
            s1 <= '0;
            s1Ok <= 1'b0;
        end else begin
            s1 <= req;
            s1Ok <= reqOk;
        end
    end

    assign s1Idx = s1.rec[AW-1:0];
    assign oneVal = {overflow[s1Idx], 15'h0, count[s1Idx], infoRd[UNIT_LSB +: UNIT_W]};
    assign twoVal = {32'h0, infoRd[32 + DETAIL_LSB +: DETAIL_W]};
    // Timestamp only shown while the record holds a valid error
    assign threeVal = (tsOn && !statusValid[s1Idx]) ? 64'h0 : tsRd;
    // Unimplemented records and absent registers read as zero
    assign regVal = !s1Ok ? 64'h0
        : (s1.which == WHICH_ONE) ? oneVal
        : (s1.which == WHICH_TWO && VERSION_ONE_ONE) ? twoVal
        : (s1.which == WHICH_THREE && VERSION_ONE_ONE) ? threeVal
        : 64'h0;
    assign next_rdata = s1.write ? 64'h0 : shapeRead(regVal, s1.half);

    // Second stage drives the answers
    always_ff @(posedge clk) begin
        if (reset) begin
            frameAck <= 1'b0;
            sysAck <= 1'b0;
            frameRdata <= 64'h0;
            sysRdata <= 64'h0;
        end else begin
            frameAck <= s1.valid && s1.fromFrame;
            sysAck <= s1.valid && !s1.fromFrame;
            frameRdata <= (s1.valid && s1.fromFrame) ? next_rdata : 64'h0;
            sysRdata <= (s1.valid && !s1.fromFrame) ? next_rdata : 64'h0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Record select field and interrupt request

    always_ff @(posedge clk) begin
        if (reset) begin
            recordSelect <= SELECT_RESET;
            faultIrq <= 1'b0;
        end else begin
            recordSelect <= selectWrite ? selectData : recordSelect;
            faultIrq <= irqEnable && (|overflowVec);
        end
    end

endmodule

`default_nettype wire

//--- bench/ems_misc_syndrome_props.sv
// Port checker for the syndrome bank.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/10ps
`default_nettype none

module ems_syn_props
    import ems_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic frameValid,
    input wire logic frameAck,
    input wire logic [63:0] frameRdata,
    input wire logic selectWrite,
    input wire logic [5:0] selectData,
    input wire logic [5:0] recordSelect,
    input wire logic sysValid,
    input wire ems_half_e sysHalf,
    input wire logic sysAck,
    input wire logic [63:0] sysRdata,
    input wire logic irqEnable,
    input wire logic faultIrq
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    ////////////////////////////////////////////////////////////////////////////////
    // Access timing and answer data
    property p_frame_ack;
        frameValid |-> ##2 frameAck;
    endproperty
    a_frame_ack: assert property (p_frame_ack) else $error("frame access not acked");
    property p_ack_cause;
        frameAck |-> $past(frameValid, 2);
    endproperty
    a_ack_cause: assert property (p_ack_cause) else $error("frame ack without request");
    property p_rdata_idle;
        !frameAck && !sysAck |-> frameRdata == 64'h0 && sysRdata == 64'h0;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside ack");
    property p_sys_ack;
        sysValid && !frameValid |-> ##2 sysAck;
    endproperty
    a_sys_ack: assert property (p_sys_ack) else $error("window access not acked");
    property p_sys_drop;
        frameValid |-> ##2 !sysAck;
    endproperty
    a_sys_drop: assert property (p_sys_drop) else $error("colliding window access acked");
    property p_half_upper;
        sysAck && $past(sysHalf, 2) != HALF_FULL |-> sysRdata[63:32] == 32'h0;
    endproperty
    a_half_upper: assert property (p_half_upper) else $error("half read upper not zero");
    property p_select;
        selectWrite |=> recordSelect == $past(selectData);
    endproperty
    a_select: assert property (p_select) else $error("record select not loaded");

    ////////////////////////////////////////////////////////////////////////////////
    // Interrupt gating and reset state
    property p_irq_gate;
        !irqEnable |=> !faultIrq;
    endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("interrupt while disabled");
    property p_reset_quiet;
        $fell(reset) |-> !frameAck && !sysAck && !faultIrq && recordSelect == 6'h00;
    endproperty
    a_reset_quiet: assert property (p_reset_quiet) else $error("outputs busy after reset");

    // Main scenarios reached
    c_frame: cover property (frameValid ##2 frameAck);
    c_sys: cover property (sysAck);
    c_irq: cover property ($fell(faultIrq));
endmodule

bind ems_misc_syndrome ems_syn_props u_props (.clk, .reset, .frameValid, .frameAck,
    .frameRdata, .selectWrite, .selectData, .recordSelect, .sysValid, .sysHalf, .sysAck,
    .sysRdata, .irqEnable, .faultIrq);
`default_nettype wire

//--- bench/tb_ems_misc_syndrome.sv
// Self-checking bench for the syndrome bank.
// Assumes four records; a second instance lacks registers two and three.
`timescale 1ns/10ps
`default_nettype none

module tb_ems_misc_syndrome
    import ems_pkg::*;
;
    typedef struct packed {
        logic [11:0] a;
        logic [63:0] d;
        logic [63:0] e;
    } ems_row_s;

    logic clk, reset, frameValid, frameWrite, selectWrite, sysValid, sysWrite, irqEnable;
    logic frameAck, sysAck, faultIrq;
    logic [11:0] frameAddr;
    logic [63:0] frameWdata, sysWdata, captureTimestamp, frameRdata, sysRdata, rd2, got, got2;
    logic [5:0] selectData, recordSelect;
    logic [1:0] sysWhich, timestampSupport;
    logic [3:0] statusValid, recordMiscValid;
    ems_half_e sysHalf;
    ems_err_s errIn;
    int n_mismatch = 0;
    int n_compared = 0;
    ems_row_s rows [6] = '{
        '{12'h028, 64'hffffffff_12345678, 64'h0000ffff_12345678},
        '{12'h070, 64'habcd0000_5a5a5a5a, 64'h00000000_5a5a5a5a},
        '{12'h0b8, 64'h01234567_89abcdef, 64'h01234567_89abcdef},
        '{12'h0e8, 64'h0, 64'h0},
        '{12'h130, 64'hffffffff_ffffffff, 64'h0},
        '{12'h020, 64'hffffffff_ffffffff, 64'h0}};

    ems_misc_syndrome dut (.*);
    ems_misc_syndrome #(.VERSION_ONE_ONE(1'b0)) dut2 (.frameRdata(rd2), .frameAck(),
        .recordSelect(), .sysAck(), .sysRdata(), .faultIrq(), .*);

    always #20 clk = ~clk;

    ////////////////////////////////////////////////////////////////////////////////
    // Compare, access and closing tasks
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic acc(input logic sys, input logic wr, input logic [11:0] a,
                       input logic [1:0] w, input ems_half_e h, input logic [63:0] d);
        @(negedge clk);
        frameValid = !sys;
        sysValid = sys;
        frameWrite = wr;
        sysWrite = wr;
        frameAddr = a;
        sysWhich = w;
        sysHalf = h;
        frameWdata = d;
        sysWdata = d;
        @(negedge clk);
        frameValid = 1'b0;
        sysValid = 1'b0;
        // Answer stands in the cycle after the first edge following the taking edge
        @(negedge clk);
        chk({63'h0, sys ? sysAck : frameAck}, 64'h1);
        got = sys ? sysRdata : frameRdata;
        got2 = rd2;
    endtask

    task automatic summarize;
        $display("compared=%0d mismatches=%0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // Watchdog against a hang
    initial begin
        #400000;
        n_mismatch++;
        summarize();
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        {clk, frameValid, frameWrite, selectWrite, sysValid, sysWrite, irqEnable} = '0;
        {frameAddr, frameWdata, sysWdata, selectData, sysWhich} = '0;
        {timestampSupport, statusValid, recordMiscValid} = '0;
        captureTimestamp = 64'h0;
        sysHalf = HALF_FULL;
        errIn = '0;
        reset = 1'b1;
        repeat (2) @(negedge clk);
        reset = 1'b0;
        chk({57'h0, faultIrq, recordSelect}, 64'h0);
        for (int i = 0; i < 6; i++) begin
            acc(1'b0, 1'b1, rows[i].a, 2'h0, HALF_FULL, rows[i].d);
            acc(1'b0, 1'b0, rows[i].a, 2'h0, HALF_FULL, 64'h0);
            chk(got, rows[i].e);
            chk(got2, rows[i].a[4] ? 64'h0 : rows[i].e);
        end
        // Latest-error field locked while misc-valid, then cleared by zero
        recordMiscValid = 4'h2;
        acc(1'b0, 1'b1, 12'h070, 2'h0, HALF_FULL, 64'h0);
        acc(1'b0, 1'b0, 12'h070, 2'h0, HALF_FULL, 64'h0);
        chk(got, 64'h5a5a5a5a);
        recordMiscValid = 4'h0;
        acc(1'b0, 1'b1, 12'h070, 2'h0, HALF_FULL, 64'h0);
        acc(1'b0, 1'b0, 12'h070, 2'h0, HALF_FULL, 64'h0);
        chk(got, 64'h0);
        // Corrected error wraps the counter and raises the interrupt
        irqEnable = 1'b1;
        errIn = '{1'b1, 6'h00, 32'hcafe0001, 32'h0bad0002, 1'b1};
        @(negedge clk);
        errIn = '0;
        @(negedge clk);
        chk({63'h0, faultIrq}, 64'h1);
        acc(1'b0, 1'b0, 12'h028, 2'h0, HALF_FULL, 64'h0);
        chk(got, 64'h80000000_cafe0001);
        irqEnable = 1'b0;
        @(negedge clk);
        chk({63'h0, faultIrq}, 64'h0);
        irqEnable = 1'b1;
        // Window view follows the record select field
        selectWrite = 1'b1;
        selectData = 6'h03;
        @(negedge clk);
        selectWrite = 1'b0;
        acc(1'b1, 1'b0, 12'h0, 2'h1, HALF_FULL, 64'h0);
        chk(got, 64'h0);
        selectWrite = 1'b1;
        selectData = 6'h00;
        @(negedge clk);
        selectWrite = 1'b0;
        acc(1'b1, 1'b0, 12'h0, 2'h1, HALF_LOW, 64'h0);
        chk(got, 64'h00000000_cafe0001);
        acc(1'b1, 1'b1, 12'h0, 2'h1, HALF_HIGH, 64'h0);
        chk({63'h0, faultIrq}, 64'h0);
        acc(1'b1, 1'b0, 12'h0, 2'h1, HALF_FULL, 64'h0);
        chk(got, 64'h00000000_cafe0001);
        // Timestamp capture, write-ignore and validity
        timestampSupport = 2'h1;
        captureTimestamp = 64'h00000001_deadbeef;
        errIn = '{1'b1, 6'h02, 32'h1, 32'h2, 1'b0};
        statusValid = 4'h4;
        @(negedge clk);
        errIn = '0;
        captureTimestamp = 64'h0;
        acc(1'b0, 1'b0, 12'h0b8, 2'h0, HALF_FULL, 64'h0);
        chk(got, 64'h00000001_deadbeef);
        acc(1'b0, 1'b1, 12'h0b8, 2'h0, HALF_FULL, 64'h0);
        acc(1'b0, 1'b0, 12'h0b8, 2'h0, HALF_FULL, 64'h0);
        chk(got, 64'h00000001_deadbeef);
        statusValid = 4'h0;
        acc(1'b0, 1'b0, 12'h0b8, 2'h0, HALF_FULL, 64'h0);
        chk(got, 64'h0);
        // Frame and window collide: only the frame is answered
        @(negedge clk);
        {frameValid, sysValid, frameWrite, sysWrite} = 4'hc;
        @(negedge clk);
        {frameValid, sysValid} = 2'h0;
        @(negedge clk);
        chk({62'h0, frameAck, sysAck}, 64'h2);
        summarize();
    end
endmodule
`default_nettype wire
